// *** serializer_link_control_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
 $display("unexpected t=%0t got %h exp %h", $time, g, e); \
 err_total++; end end
module serializer_link_control_regs_tb;
   localparam int HOLD = 20;
   logic        clk_i, rst_i, cyc, stb, we, ack, irq;
   logic [7:0]  adr;
   logic [3:0]  sel, want;
   logic [31:0] wdat, rdat, q;
   logic [1:0]  mf, pf, swing;
   logic [3:0]  emph;
   logic        run, slp, i2c, uart, rx, tx, omit, byp, as_pin, cds_pin;
   logic [7:0]  m [16];
   int          err_total, n_compared, seed, cnt;

   // Far-end monitor drives the fault inputs
   slc_fault_line_model fl_u (.clk_i(clk_i), .want_i(want),
      .minus_o(mf), .plus_o(pf));

   slc_link_regs #(.HOLD_CYC(HOLD)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .auto_start_pin_i(as_pin), .channel_side_select_pin_i(cds_pin),
      .minus_wire_fault_i(mf), .plus_wire_fault_i(pf),
      .link_run_enable_o(run), .sleep_o(slp), .base_i2c_enable_o(i2c),
      .base_uart_enable_o(uart), .back_channel_rx_enable_o(rx),
      .forward_channel_tx_enable_o(tx), .conversion_address_omit_o(omit),
      .jitter_filter_bypass_o(byp), .driver_swing_select_o(swing),
      .driver_emphasis_code_o(emph), .irq_o(irq));

   // Free-running 40 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // Model write: illegal swing or emphasis codes leave the field alone
   function automatic void mwr(logic [7:0] a, logic [7:0] d);
      int i;
      i = a[7:2];
      if (i == 5 && d[5:4] == 2'h0) d[5:4] = m[5][5:4];
      if (i == 5 && d[3:0] inside {[5:7]}) d[3:0] = m[5][3:0];
      if (i inside {[4:7], 10}) m[i] = d;
   endfunction : mwr

   // One classic cycle; request held until ack is seen on an edge
   task automatic wb(input logic w, input int i, input logic [7:0] d,
      input logic s);
      int n;
      n = 0;
      @(posedge clk_i);
      {cyc, stb, we} <= {2'b11, w};
      adr <= 8'(i * 4);
      wdat <= {24'h0, d};
      sel <= {3'h0, s};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      {cyc, stb, we} <= 3'b000;
      if (n >= 20) err_total++;
      if (w && s) mwr(8'(i * 4), d);
   endtask : wb

   task automatic rd(input int i);
      wb(1'b0, i, 8'h00, 1'b0);
      `CHK(q, {24'h0, m[i]})
   endtask : rd

   // Outputs settle on the same edge as the commit
   task automatic chk_out(input logic rx_e);
      repeat (2) @(posedge clk_i);
      #1;
      `CHK({run, slp, tx, omit, byp}, {m[4][7], m[4][4], m[4][0],
          m[5][7], m[5][6]})
      `CHK({i2c, uart}, {m[4][3:2] == 2'h0, m[4][3:2] == 2'h1})
      `CHK({swing, emph}, m[5][5:0])
      `CHK(rx, rx_e)
   endtask : chk_out

   task automatic tally_and_finish();
      $display("compared %0d errors %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish

   // Hang guard sized well past the sequence below
   initial begin
      #(25 * 20000);
      err_total++;
      tally_and_finish();
   end

   initial begin
      {cyc, stb, we, adr, sel, wdat} = '0;
      {err_total, n_compared, cnt} = '0;
      seed = 44785;
      want = 4'hA;
      {as_pin, cds_pin} = 2'b01;
      rst_i = 1'b1;
      m = '{default: 8'h00};
      {m[4], m[5], m[6], m[7], m[8]} = 40'h83_70_40_22_0A;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      // Strapped start: link runs, back channel held off at first
      repeat (2) @(posedge clk_i);
      #1;
      `CHK({run, rx}, 2'b10)
      // Reset values, reserved defaults and an unmapped hole
      foreach (m[i]) if (i >= 4 && i != 9) rd(i);
      chk_out(1'b1);
      // Stop, restart and stop again, timing each back-channel hold-off
      for (int j = 0; j < 3; j++) begin
         wb(1'b1, 4, {j[0], 7'h03}, 1'b1);
         cnt = 0;
         do begin
            @(posedge clk_i);
            #1;
            cnt++;
         end while (rx !== 1'b1 && cnt < 200);
         `CHK(cnt >= HOLD && cnt <= HOLD + 3, 1'b1)
         `CHK(run, j[0])
      end
      // Expiry event, masking, clearing, then a fault event
      wb(1'b0, 9, 8'h00, 1'b0);
      `CHK(q[1:0], 2'h1)
      `CHK(irq, 1'b0)
      wb(1'b1, 10, 8'h01, 1'b1);
      chk_out(1'b1);
      `CHK(irq, 1'b1)
      wb(1'b1, 9, 8'h01, 1'b1);
      chk_out(1'b1);
      `CHK(irq, 1'b0)
      wb(1'b1, 10, 8'h03, 1'b1);
      want <= 4'h7;
      m[8] = 8'h07;
      repeat (6) @(posedge clk_i);
      `CHK(irq, 1'b1)
      rd(8);
      wb(1'b0, 9, 8'h00, 1'b0);
      `CHK(q[1:0], 2'h2)
      // Every select, swing and emphasis code, reserved ones included
      for (int k = 0; k < 16; k++) begin
         wb(1'b1, 4, {3'h0, k[2], k[1:0], 2'h3}, 1'b1);
         wb(1'b1, 5, {k[3:2], k[1:0], k[3:0]}, 1'b1);
         chk_out(1'b1);
         rd(5);
      end
      // Random traffic, run bit held low so no hold-off interferes
      repeat (24) begin
         cnt = {$random(seed)} % 4;
         wb(1'b1, (cnt == 3) ? 15 : 4 + cnt * 2 - (cnt == 2),
            8'($random(seed)) & 8'h7F, 1'($random(seed)));
         rd(4);
         rd(5);
         chk_out(m[4][1]);
      end
      // Second reset with both straps high: link stays off, sleep is set
      @(posedge clk_i);
      rst_i <= 1'b1;
      {as_pin, cds_pin} <= 2'b11;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      {m[4], m[5], m[10]} = 24'h13_70_00;
      rd(4);
      rd(5);
      rd(10);
      chk_out(1'b1);
      tally_and_finish();
   end
endmodule : serializer_link_control_regs_tb
`default_nettype wire

// *** slc_cfg.svh ***
`ifndef SLC_CFG_SVH
`define SLC_CFG_SVH

// Register indices; byte address is four times the index
`define SLC_IDX_LINK   6'h04
`define SLC_IDX_DRV    6'h05
`define SLC_IDX_RSV6   6'h06
`define SLC_IDX_RSV7   6'h07
`define SLC_IDX_FAULT  6'h08
`define SLC_IDX_IRQST  6'h09
`define SLC_IDX_IRQMSK 6'h0A

// Field positions
`define SLC_B_RUN      7
`define SLC_B_SLEEP    4
`define SLC_B_PSEL_HI  3
`define SLC_B_PSEL_LO  2
`define SLC_B_RXEN     1
`define SLC_B_TXEN     0
`define SLC_B_OMIT     7
`define SLC_B_BYP      6
`define SLC_B_SW_HI    5
`define SLC_B_SW_LO    4

// Reset values and the reserved swing code
`define SLC_RST_LINK   8'h03
`define SLC_RST_DRV    8'h70
`define SLC_RST_RSV6   8'h40
`define SLC_RST_RSV7   8'h22
`define SLC_FAULT_OK   2'h2
`define SLC_SWING_BAD  2'h0

// Interrupt status bits
`define SLC_EV_RXREADY 0
`define SLC_EV_FAULT   1

// Timing
`define SLC_CLK_NS     25
`define SLC_HOLD_NS    350000

`endif

// *** slc_fault_line_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Line monitor at the far end: reports wire health as registered levels
module slc_fault_line_model (
   input  wire logic       clk_i,
   input  wire logic [3:0] want_i,
   output logic [1:0]      minus_o,
   output logic [1:0]      plus_o
);
   // Codes move on a clock edge, as a real monitor's would
   always_ff @(posedge clk_i) begin
      minus_o <= want_i[3:2];
      plus_o  <= want_i[1:0];
   end
endmodule : slc_fault_line_model
`default_nettype wire

// *** slc_hold_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module slc_hold_timer #(
   parameter int CYC = 14000
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic start_i,
   output logic      busy_o,
   output logic      done_o
);
   localparam int W = $clog2(CYC + 1);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic         done_r;
   logic         done_nxt;

   // A restart while counting reloads, so the hold always runs in full
   always_comb begin
      cnt_nxt  = cnt_r;
      done_nxt = 1'b0;
      if (start_i) begin
         cnt_nxt = W'(CYC);
      end else if (cnt_r != '0) begin
         cnt_nxt  = cnt_r - 1'b1;
         done_nxt = (cnt_r == W'(1));
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r  <= '0;
         done_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         done_r <= done_nxt;
      end
   end

   assign busy_o = (cnt_r != '0);
   assign done_o = done_r;
endmodule : slc_hold_timer
`default_nettype wire

// *** slc_link_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "slc_cfg.svh"
module slc_link_regs #(
   parameter int HOLD_CYC =
      (`SLC_HOLD_NS + `SLC_CLK_NS - 1) / `SLC_CLK_NS
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       wb_cyc_i,
   input  wire logic       wb_stb_i,
   input  wire logic       wb_we_i,
   input  wire logic [7:0] wb_adr_i,
   input  wire logic [3:0] wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]     wb_dat_o,
   output logic            wb_ack_o,
   input  wire logic       auto_start_pin_i,
   input  wire logic       channel_side_select_pin_i,
   input  wire logic [1:0] minus_wire_fault_i,
   input  wire logic [1:0] plus_wire_fault_i,
   output logic            link_run_enable_o,
   output logic            sleep_o,
   output logic            base_i2c_enable_o,
   output logic            base_uart_enable_o,
   output logic            back_channel_rx_enable_o,
   output logic            forward_channel_tx_enable_o,
   output logic            conversion_address_omit_o,
   output logic            jitter_filter_bypass_o,
   output logic [1:0]      driver_swing_select_o,
   output logic [3:0]      driver_emphasis_code_o,
   output logic            irq_o
);
   slc_pkg::slc_byte_t  ctl_r, ctl_nxt, drv_r, drv_nxt;
   slc_pkg::slc_byte_t  rsv6_r, rsv6_nxt, rsv7_r, rsv7_nxt;
   slc_pkg::slc_byte_t  sts_r, sts_nxt, msk_r, msk_nxt;
   slc_pkg::slc_fault_t mflt_r, mflt_nxt, pflt_r, pflt_nxt;
   logic        ack_r, ack_nxt, strap_r;
   logic [31:0] dat_r, dat_nxt;
   logic        wr, take, hold_start, hold_busy, hold_done;
   logic [5:0]  idx;
   slc_pkg::slc_byte_t  rd, wv;
   slc_pkg::slc_psel_t  psel;

   // Back-channel hold-off, restarted on every run/stop change
   slc_hold_timer #(
      .CYC     (HOLD_CYC)
   ) u_hold (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .start_i (hold_start),
      .busy_o  (hold_busy),
      .done_o  (hold_done)
   );

   assign idx  = wb_adr_i[7:2];
   assign take = wb_cyc_i & wb_stb_i;
   // Write commits at the edge where the master sees ack
   assign wr   = take & wb_we_i & ack_r & wb_sel_i[0];
   assign wv   = wb_dat_i[7:0];

   // Register read mux; unmapped indices read zero
   always_comb begin
      case (idx)
         `SLC_IDX_LINK:   rd = ctl_r;
         `SLC_IDX_DRV:    rd = drv_r;
         `SLC_IDX_RSV6:   rd = rsv6_r;
         `SLC_IDX_RSV7:   rd = rsv7_r;
         `SLC_IDX_FAULT:  rd = {4'h0, mflt_r, pflt_r};
         `SLC_IDX_IRQST:  rd = sts_r;
         `SLC_IDX_IRQMSK: rd = msk_r;
         default:         rd = 8'h00;
      endcase
   end

   // Bus, register and interrupt state
   always_comb begin
      ctl_nxt  = ctl_r;
      drv_nxt  = drv_r;
      rsv6_nxt = rsv6_r;
      rsv7_nxt = rsv7_r;
      msk_nxt  = msk_r;
      sts_nxt  = sts_r;
      ack_nxt  = take & ~ack_r;
      dat_nxt  = ack_nxt ? {24'h000000, rd} : 32'h00000000;
      mflt_nxt = minus_wire_fault_i;
      pflt_nxt = plus_wire_fault_i;
      if (wr) begin
         case (idx)
            `SLC_IDX_LINK: ctl_nxt = wv;
            `SLC_IDX_DRV: begin
               drv_nxt[`SLC_B_OMIT] = wv[`SLC_B_OMIT];
               drv_nxt[`SLC_B_BYP]  = wv[`SLC_B_BYP];
               if (wv[`SLC_B_SW_HI:`SLC_B_SW_LO] != `SLC_SWING_BAD) begin
                  drv_nxt[`SLC_B_SW_HI:`SLC_B_SW_LO] =
                     wv[`SLC_B_SW_HI:`SLC_B_SW_LO];
               end
               if (!(wv[3:2] == 2'h1 && wv[1:0] != 2'h0)) begin
                  drv_nxt[3:0] = wv[3:0];
               end
            end
            `SLC_IDX_RSV6:   rsv6_nxt = wv;
            `SLC_IDX_RSV7:   rsv7_nxt = wv;
            `SLC_IDX_IRQST:  sts_nxt  = sts_r & ~wv;
            `SLC_IDX_IRQMSK: msk_nxt  = wv;
            default: ;
         endcase
      end
      // strap levels caught once after reset release
      if (strap_r) begin
         ctl_nxt[`SLC_B_RUN]   = ~auto_start_pin_i;
         ctl_nxt[`SLC_B_SLEEP] = auto_start_pin_i &
                                 channel_side_select_pin_i;
      end
      // Events set after the clear so a coincident event wins
      if (hold_done) begin
         sts_nxt[`SLC_EV_RXREADY] = 1'b1;
      end
      if (mflt_nxt != mflt_r || pflt_nxt != pflt_r) begin
         sts_nxt[`SLC_EV_FAULT] = 1'b1;
      end
   end

   assign hold_start = (ctl_nxt[`SLC_B_RUN] != ctl_r[`SLC_B_RUN]);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl_r   <= `SLC_RST_LINK;
         drv_r   <= `SLC_RST_DRV;
         rsv6_r  <= `SLC_RST_RSV6;
         rsv7_r  <= `SLC_RST_RSV7;
         sts_r   <= 8'h00;
         msk_r   <= 8'h00;
         mflt_r  <= `SLC_FAULT_OK;
         pflt_r  <= `SLC_FAULT_OK;
         ack_r   <= 1'b0;
         dat_r   <= 32'h00000000;
         strap_r <= 1'b1;
      end else begin
         ctl_r   <= ctl_nxt;
         drv_r   <= drv_nxt;
         rsv6_r  <= rsv6_nxt;
         rsv7_r  <= rsv7_nxt;
         sts_r   <= sts_nxt;
         msk_r   <= msk_nxt;
         mflt_r  <= mflt_nxt;
         pflt_r  <= pflt_nxt;
         ack_r   <= ack_nxt;
         dat_r   <= dat_nxt;
         strap_r <= 1'b0;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;

   // Peripheral selection decode
   always_comb begin
      case (ctl_nxt[`SLC_B_PSEL_HI:`SLC_B_PSEL_LO])
         2'h0:    psel = slc_pkg::SLC_PS_I2C;
         2'h1:    psel = slc_pkg::SLC_PS_UART;
         default: psel = slc_pkg::SLC_PS_OFF;
      endcase
   end

   // Outputs registered from the next-state values
   logic o_run, o_slp, o_i2c, o_uart, o_rx, o_tx, o_omit, o_byp, o_irq;
   logic [1:0] o_sw;
   logic [3:0] o_em;
   always_comb begin
      o_run  = ctl_nxt[`SLC_B_RUN];
      o_slp  = ctl_nxt[`SLC_B_SLEEP];
      o_i2c  = (psel == slc_pkg::SLC_PS_I2C);
      o_uart = (psel == slc_pkg::SLC_PS_UART);
      // receive gated by bit and hold-off
      o_rx   = ctl_nxt[`SLC_B_RXEN] & ~hold_start & ~hold_busy;
      o_tx   = ctl_nxt[`SLC_B_TXEN];
      o_omit = drv_nxt[`SLC_B_OMIT];
      o_byp  = drv_nxt[`SLC_B_BYP];
      o_sw   = drv_nxt[`SLC_B_SW_HI:`SLC_B_SW_LO];
      o_em   = drv_nxt[3:0];
      o_irq  = |(sts_nxt & msk_nxt);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         link_run_enable_o           <= 1'b0;
         sleep_o                     <= 1'b0;
         base_i2c_enable_o           <= 1'b0;
         base_uart_enable_o          <= 1'b0;
         back_channel_rx_enable_o    <= 1'b0;
         forward_channel_tx_enable_o <= 1'b0;
         conversion_address_omit_o   <= 1'b0;
         jitter_filter_bypass_o      <= 1'b1;
         driver_swing_select_o       <= 2'h3;
         driver_emphasis_code_o      <= 4'h0;
         irq_o                       <= 1'b0;
      end else begin
         link_run_enable_o           <= o_run;
         sleep_o                     <= o_slp;
         base_i2c_enable_o           <= o_i2c;
         base_uart_enable_o          <= o_uart;
         back_channel_rx_enable_o    <= o_rx;
         forward_channel_tx_enable_o <= o_tx;
         conversion_address_omit_o   <= o_omit;
         jitter_filter_bypass_o      <= o_byp;
         driver_swing_select_o       <= o_sw;
         driver_emphasis_code_o      <= o_em;
         irq_o                       <= o_irq;
      end
   end

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_run_flip;
      $changed(link_run_enable_o);
   endsequence
   sequence s_read_fault;
      take && !wb_we_i && !ack_r && idx == `SLC_IDX_FAULT;
   endsequence
   // Three outputs (I2C enable, receive, transmit) reset to values that differ from the register reset values
   sequence s_settled;
      !rst_i && !$past(rst_i);
   endsequence

   chk_hold_block: assert property (
      s_run_flip |-> !back_channel_rx_enable_o [*8])
      else $error("back channel open during hold-off");
   chk_hold_len: assert property (
      $rose(hold_busy) |-> hold_busy [*8])
      else $error("hold-off ended too early");
   chk_strap_sleep: assert property (
      strap_r && !rst_i |=>
         sleep_o == $past(auto_start_pin_i & channel_side_select_pin_i))
      else $error("sleep strap not applied");
   chk_i2c_pick: assert property (
      base_i2c_enable_o |-> ctl_r[3:2] == 2'h0 && !base_uart_enable_o)
      else $error("I2C selected with wrong code");
   chk_periph_off: assert property (
      ctl_r[`SLC_B_PSEL_HI] |-> !base_i2c_enable_o && !base_uart_enable_o)
      else $error("peripheral active while disabled");
   chk_rx_gate: assert property (
      !ctl_r[`SLC_B_RXEN] |-> !back_channel_rx_enable_o)
      else $error("receive open with enable clear");
   chk_tx_gate: assert property (
      s_settled |-> forward_channel_tx_enable_o == ctl_r[`SLC_B_TXEN])
      else $error("forward gate mismatch");
   chk_omit_follow: assert property (
      conversion_address_omit_o == drv_r[`SLC_B_OMIT])
      else $error("address-omit output mismatch");
   chk_swing_legal: assert property (
      driver_swing_select_o != `SLC_SWING_BAD)
      else $error("unused swing code driven");
   chk_fault_read: assert property (
      s_read_fault ##1 1'b1 |-> wb_dat_o[3:0] == {mflt_r, pflt_r} ||
         $changed(mflt_r) || $changed(pflt_r))
      else $error("fault field readback wrong");
   chk_fault_upper: assert property (
      s_read_fault |=> wb_ack_o && wb_dat_o[31:4] == 28'h0)
      else $error("fault upper bits not zero");
   chk_emph_legal: assert property (
      !(driver_emphasis_code_o[3:2] == 2'h1 &&
        driver_emphasis_code_o[1:0] != 2'h0))
      else $error("reserved emphasis code driven");
   // Registered copies agree with their register once reset has settled
   chk_run_follow: assert property (
      s_settled |-> link_run_enable_o == ctl_r[`SLC_B_RUN])
      else $error("run output differs from register");
   chk_expiry_event: assert property (
      hold_done |=> sts_r[`SLC_EV_RXREADY])
      else $error("hold-off expiry not recorded");
   chk_irq_level: assert property (
      irq_o == |(sts_r & msk_r))
      else $error("interrupt level mismatch");
   chk_sleep_follow: assert property (
      s_settled |-> sleep_o == ctl_r[`SLC_B_SLEEP])
      else $error("sleep output differs from register");
   chk_uart_pick: assert property (
      base_uart_enable_o |-> ctl_r[3:2] == 2'h1 && !base_i2c_enable_o)
      else $error("UART selected with wrong code");
   // A reopening must never fall inside a hold-off window
   chk_rx_reopen: assert property (
      $rose(back_channel_rx_enable_o) |-> ctl_r[`SLC_B_RXEN] && !hold_busy)
      else $error("back channel reopened too early");
   chk_swing_follow: assert property (
      s_settled |->
         driver_swing_select_o == drv_r[`SLC_B_SW_HI:`SLC_B_SW_LO])
      else $error("swing output differs from register");
   chk_emph_follow: assert property (
      s_settled |-> driver_emphasis_code_o == drv_r[3:0])
      else $error("emphasis output differs from register");
   chk_fault_sample: assert property (
      s_settled |-> {mflt_r, pflt_r} ==
         $past({minus_wire_fault_i, plus_wire_fault_i}))
      else $error("fault codes not sampled");
endmodule : slc_link_regs
`default_nettype wire

// *** slc_pkg.sv ***
package slc_pkg;
   typedef logic [7:0] slc_byte_t;
   typedef logic [1:0] slc_fault_t;
   typedef enum {SLC_PS_I2C, SLC_PS_UART, SLC_PS_OFF} slc_psel_t;
endpackage : slc_pkg
